// >>> include/svd_defs.vh
/*
 Constants for the supply voltage detect controller: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the design file.
*/
// Notes on behaviour
// - Crossing in chosen direction sets detect event flag
// - Enabled set flag raises interrupt request
// - Bit 7 picks rising or falling trigger
// - Bit 4 powers detector; clearing switches off
// - Bits 3-0 pick level; 1111 external pin
// - Reference-stable held low after each enable
// - Bit 5 read-only stable flag, writes ignored
// - No events while reference not stable
// - Bit 6 reads zero, writes ignored
// - Reset restores control register, detector off
`ifndef SVD_DEFS_VH
`define SVD_DEFS_VH
`define SVD_OFS_CONTROL    4'h0
`define SVD_OFS_STATUS     4'h4
`define SVD_OFS_IRQ_ENABLE 4'h8
`define SVD_OFS_IRQ_CLEAR  4'hc
`define SVD_BIT_DIR        7
`define SVD_BIT_STABLE     5
`define SVD_BIT_ENABLE     4
`define SVD_LEVEL_EXT      4'hf
`define SVD_CONTROL_RESET  8'h05
`define SVD_WR_MASK        8'h9f
`define SVD_SETTLE_NS      1000
`define SVD_CLK_NS         10
`define SVD_SETTLE_CYCLES  ((`SVD_SETTLE_NS + `SVD_CLK_NS - 1) / `SVD_CLK_NS)
`define SVD_RESP_OKAY      2'b00
`define SVD_RESP_SLVERR    2'b10
`endif

// >>> tb/svdc_checker.sv
/* Port checker for svd_ctrl.
   Assumes one clock aclk and synchronous active-low aresetn. */
`timescale 1ns/100ps
module svdc_checker (
    // Clock and reset
    input logic       aclk,
    input logic       aresetn,
    // Bus handshakes
    input logic       s_axi_bvalid,
    input logic       s_axi_arvalid,
    input logic       s_axi_arready,
    input logic       s_axi_rvalid,
    // Front end and interrupt
    input logic       comparator_trip_async,
    input logic       reference_ready_async,
    input logic       detector_power_enable,
    input logic [3:0] trip_level_select,
    input logic       external_trip_input_sel,
    input logic       direction_select,
    input logic       irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Quiet interrupt rise: not a side effect of a register write
    sequence ev_rise_s;
        $rose(irq) && !s_axi_bvalid && !$past(s_axi_bvalid);
    endsequence
    ext_sel_a: assert property (external_trip_input_sel == (trip_level_select == 4'hf))
        else $error("external select does not follow level code");
    cfg_write_a: assert property ($changed({direction_select, detector_power_enable})
        |-> $past(s_axi_bvalid)) else $error("control output changed without a write");
    event_cause_a: assert property (ev_rise_s |-> $past(comparator_trip_async, 3))
        else $error("interrupt rose without a comparator crossing");
    stable_gate_a: assert property (ev_rise_s |-> $past(reference_ready_async, 3))
        else $error("interrupt rose without a ready reference");
    settle_hold_a: assert property ($rose(detector_power_enable) |=> (!$rose(irq)) [*4])
        else $error("event raised during settle time");
    irq_drop_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without a write");
    reset_off_a: assert property ($rose(aresetn) |-> !detector_power_enable && !irq)
        else $error("detector or interrupt active after reset");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property ($rose(detector_power_enable));
endmodule // svdc_checker
bind svd_ctrl svdc_checker chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .comparator_trip_async, .reference_ready_async,
    .detector_power_enable, .trip_level_select, .external_trip_input_sel,
    .direction_select, .irq);

// >>> tb/testbench.sv
/* Self-checking bench for svd_ctrl over AXI4-Lite.
   Assumes a short settle count of 4 cycles. */
`timescale 1ns/100ps
module testbench;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        comparator_trip_async = 0, reference_ready_async = 0, s_axi_arready;
    logic        s_axi_rvalid, detector_power_enable, external_trip_input_sel, irq;
    logic        direction_select;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, trip_level_select;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_fail = 0, compares = 0, cyc = 0;
    svd_ctrl #(.SETTLE_CYCLES(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .comparator_trip_async, .reference_ready_async, .detector_power_enable,
        .trip_level_select, .external_trip_input_sel, .direction_select, .irq);
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [31:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, er);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] ed, input logic [31:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, er);
    endtask
    task wait_cmp(input logic v);
        comparator_trip_async <= v;
        repeat (8) @(posedge aclk);
    endtask
    task t_reset;
        rd(4'h0, 32'h05, 32'h0);
        rd(4'h4, 32'h0, 32'h0);
        rd(4'hc, 32'h0, 32'h0);
    endtask
    task t_fields;
        wr(4'h0, 32'hff, 32'h0);
        @(negedge aclk);
        chk({direction_select, external_trip_input_sel, detector_power_enable}, 3'h7);
        rd(4'h0, 32'h9f, 32'h0);
        wait_cmp(1'b1);
        rd(4'h4, 32'h0, 32'h0);
        wait_cmp(1'b0);
        wr(4'h4, 32'h1, 32'h2);
        rd(4'h2, 32'h0, 32'h2);
        wr(4'h0, 32'h0, 32'h0);
        @(negedge aclk);
        chk(detector_power_enable, 1'b0);
    endtask
    task t_event;
        reference_ready_async <= 1'b1;
        wr(4'h0, 32'h1e, 32'h0);
        @(negedge aclk);
        chk({direction_select, external_trip_input_sel}, 2'h0);
        rd(4'h0, 32'h1e, 32'h0);
        repeat (10) @(posedge aclk);
        rd(4'h0, 32'h3e, 32'h0);
        wait_cmp(1'b1);
        rd(4'h4, 32'h1, 32'h0);
        chk(irq, 1'b0);
        wr(4'h8, 32'h1, 32'h0);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(4'hc, 32'h1, 32'h0);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        rd(4'h4, 32'h0, 32'h0);
        wait_cmp(1'b0);
        wr(4'h0, 32'h0e, 32'h0);
        rd(4'h0, 32'h0e, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_event();
        wrap_up();
    end
endmodule // testbench

// >>> verilog/svd_ctrl.v
/*
 Supply voltage detect controller: AXI4-Lite register slave, control
 register, reference settle timer, synchronised comparator event logic
 and a level interrupt.
 Assumes the analog comparator and reference-ready inputs are
 asynchronous; every other input is synchronous to aclk.
*/
`timescale 1ns/100ps
`include "svd_defs.vh"
module svd_ctrl #(
    parameter SETTLE_CYCLES = `SVD_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Analog front end
    input  wire        comparator_trip_async,
    input  wire        reference_ready_async,
    output reg         detector_power_enable,
    output reg  [3:0]  trip_level_select,
    output reg         external_trip_input_sel,
    output reg         direction_select,
    // Interrupt
    output reg         irq
);
    // Settle count cut to the counter width on purpose
    localparam [15:0] SETTLE_LIMIT = SETTLE_CYCLES;
    reg  [7:0]  ctrl_reg;
    reg         detect_event_flag_reg;
    reg         detect_irq_enable_reg;
    reg  [1:0]  cmp_sync_reg;
    reg  [1:0]  rdy_sync_reg;
    reg         cmp_prev_reg;
    reg         stable_reg;
    reg  [15:0] settle_cnt_reg;
    reg         aw_hold_reg;
    reg         w_hold_reg;
    reg  [3:0]  awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    wire        enabled;
    wire        wr_fire;
    wire        cmp_rise;
    wire        event_set;
    wire        clr_write;
    wire [7:0]  ctrl_view;
    wire [3:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;

    assign enabled = ctrl_reg[`SVD_BIT_ENABLE];
    // Comparator reports "condition true" for the selected direction
    assign cmp_rise  = cmp_sync_reg[1] & ~cmp_prev_reg;
    assign event_set = enabled & stable_reg & cmp_rise;
    assign ctrl_view = {ctrl_reg[7], 1'b0, stable_reg, ctrl_reg[4:0]};

    assign wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    assign wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    assign wr_fire = (aw_hold_reg | (s_axi_awvalid & s_axi_awready))
                   & (w_hold_reg | (s_axi_wvalid & s_axi_wready));
    assign clr_write = wr_fire & (wr_addr == `SVD_OFS_IRQ_CLEAR) & wr_strb[0] & wr_data[0];

    // Synchronisers and settle timer
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmp_sync_reg   <= 2'b00;
            rdy_sync_reg   <= 2'b00;
            cmp_prev_reg   <= 1'b0;
            stable_reg     <= 1'b0;
            settle_cnt_reg <= 16'h0000;
        end else begin
            cmp_sync_reg <= {cmp_sync_reg[0], comparator_trip_async};
            rdy_sync_reg <= {rdy_sync_reg[0], reference_ready_async};
            cmp_prev_reg <= cmp_sync_reg[1];
            if (!enabled) begin
                settle_cnt_reg <= 16'h0000;
                stable_reg     <= 1'b0;
            end else if (settle_cnt_reg < SETTLE_LIMIT) begin
                settle_cnt_reg <= settle_cnt_reg + 16'h0001;
                stable_reg     <= 1'b0;
            end else begin
                stable_reg <= rdy_sync_reg[1];
            end
        end
    end

    // Event flag: set wins over clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            detect_event_flag_reg <= 1'b0;
        end else if (event_set) begin
            detect_event_flag_reg <= 1'b1;
        end else if (clr_write) begin
            detect_event_flag_reg <= 1'b0;
        end
    end

    // Write channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg              <= `SVD_CONTROL_RESET;
            detect_irq_enable_reg <= 1'b0;
            aw_hold_reg           <= 1'b0;
            w_hold_reg            <= 1'b0;
            awaddr_reg            <= 4'h0;
            wdata_reg             <= 32'h00000000;
            wstrb_reg             <= 4'h0;
            s_axi_awready         <= 1'b0;
            s_axi_wready          <= 1'b0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `SVD_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_hold_reg & ~s_axi_bvalid & ~s_axi_awready;
            s_axi_wready  <= ~w_hold_reg & ~s_axi_bvalid & ~s_axi_wready;
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_reg   <= 1'b0;
                w_hold_reg    <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= (wr_addr[1:0] != 2'b00 || wr_addr == `SVD_OFS_STATUS)
                               ? `SVD_RESP_SLVERR : `SVD_RESP_OKAY;
                if (wr_addr == `SVD_OFS_CONTROL && wr_strb[0]) begin
                    ctrl_reg <= wr_data[7:0] & `SVD_WR_MASK;
                end
                if (wr_addr == `SVD_OFS_IRQ_ENABLE && wr_strb[0]) begin
                    detect_irq_enable_reg <= wr_data[0];
                end
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_hold_reg <= 1'b1;
                    awaddr_reg  <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_hold_reg <= 1'b1;
                    wdata_reg  <= s_axi_wdata;
                    wstrb_reg  <= s_axi_wstrb;
                end
            end
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SVD_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `SVD_RESP_OKAY;
                case (s_axi_araddr)
                    `SVD_OFS_CONTROL:    s_axi_rdata <= {24'h000000, ctrl_view};
                    `SVD_OFS_STATUS:     s_axi_rdata <= {31'h00000000, detect_event_flag_reg};
                    `SVD_OFS_IRQ_ENABLE: s_axi_rdata <= {31'h00000000, detect_irq_enable_reg};
                    `SVD_OFS_IRQ_CLEAR:  s_axi_rdata <= 32'h00000000;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `SVD_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Front end drive and interrupt
    always @(posedge aclk) begin
        if (!aresetn) begin
            detector_power_enable   <= 1'b0;
            trip_level_select       <= 4'h0;
            external_trip_input_sel <= 1'b0;
            direction_select        <= 1'b0;
            irq                     <= 1'b0;
        end else begin
            detector_power_enable   <= enabled;
            trip_level_select       <= ctrl_reg[3:0];
            external_trip_input_sel <= (ctrl_reg[3:0] == `SVD_LEVEL_EXT);
            direction_select        <= ctrl_reg[`SVD_BIT_DIR];
            irq <= (detect_event_flag_reg | event_set) & detect_irq_enable_reg;
        end
    end
endmodule // svd_ctrl
